//--- rtl/cbt_map.svh
// constants for the branch and carry-bit instruction timing block
// assumes the includer compiles it once per unit; cycles are core clocks
// Notes on behaviour
// - and-not-bit into carry: 2 bytes, 2 cycles
// - or-bit into carry: 2 bytes, 2 cycles
// - or-not-bit into carry: 2 bytes, 2 cycles
// - copy bit to carry: 2 bytes, 2 cycles
// - copy carry to bit: 2 bytes, 2 cycles
// - carry branches: 2 bytes, 2 or 3 cycles
// - bit branches: 3 bytes, 3 or 4 cycles
// - branch-and-clear bit: 3 bytes, 3/4 cycles
// - absolute call: 2 bytes, 3 cycles
// - long call: 3 bytes, 4 cycles
// - subroutine return: 1 byte, 5 cycles
// - interrupt return: 1 byte, 5 cycles
// - short relative jump: 2 bytes, 3 cycles
// - indirect pointer jump: 1 byte, 3 cycles
// - accumulator zero branches: 2 bytes, 2/3 cycles
// - compare acc with direct: 3 bytes, 3/4
// - compare acc with immediate: 3 bytes, 3/4
// - compare register with immediate: 3/4 cycles
// - compare indirect with immediate: 3 bytes, 4/5
// - decrement register branch: 2 bytes, 2/3 cycles
// - decrement direct branch: 3 bytes, 3/4 cycles
`ifndef CBT_MAP_SVH
`define CBT_MAP_SVH

// -----------------------------------------------------------------
// opcodes
// -----------------------------------------------------------------
`define CBT_OP_ANDN   8'hB0
`define CBT_OP_OR     8'h72
`define CBT_OP_ORN    8'hA0
`define CBT_OP_LDC    8'hA2
`define CBT_OP_STC    8'h92
`define CBT_OP_JC     8'h40
`define CBT_OP_JNC    8'h50
`define CBT_OP_JB     8'h20
`define CBT_OP_JNB    8'h30
`define CBT_OP_JBC    8'h10
`define CBT_OP_ABSOLUTE_CALL  8'b???1_0001
`define CBT_OP_LONG_CALL  8'h12
`define CBT_OP_RET    8'h22
`define CBT_OP_INTERRUPT_RETURN   8'h32
`define CBT_OP_SHORT_RELATIVE_JUMP   8'h80
`define CBT_OP_JMPI   8'h73
`define CBT_OP_JZ     8'h60
`define CBT_OP_JNZ    8'h70
`define CBT_OP_CJD    8'hB5
`define CBT_OP_CJI    8'hB4
`define CBT_OP_CJR    8'b1011_1???
`define CBT_OP_CJX    8'b1011_011?
`define CBT_OP_DJR    8'b1101_1???
`define CBT_OP_DJD    8'hD5

// -----------------------------------------------------------------
// lengths in bytes and cycle counts
// -----------------------------------------------------------------
`define CBT_LEN_1     2'h1
`define CBT_LEN_2     2'h2
`define CBT_LEN_3     2'h3
`define CBT_CYC_1     3'h1
`define CBT_CYC_2     3'h2
`define CBT_CYC_3     3'h3
`define CBT_CYC_4     3'h4
`define CBT_CYC_5     3'h5
`define CBT_CNT_FIRST 3'h1
`define CBT_BYTE_ZERO 8'h00
`define CBT_BYTE_ONE  8'h01

`endif

//--- rtl/cbt_pkg.sv
// types for the branch and carry-bit instruction timing block
// assumes cbt_map.svh supplies all numeric constants
package cbt_pkg;

	// -----------------------------------------------------------------
	// enums
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		CBT_IDLE = 2'b00,
		CBT_EXEC = 2'b01
	} cbt_state_e;

	typedef enum logic [3:0] {
		CBT_CND_NONE, CBT_CND_C, CBT_CND_NC, CBT_CND_B, CBT_CND_NB,
		CBT_CND_BC, CBT_CND_Z, CBT_CND_NZ, CBT_CND_NE, CBT_CND_DJ
	} cbt_cond_e;

	typedef enum logic [2:0] {
		CBT_FX_NONE, CBT_FX_ANDN, CBT_FX_OR, CBT_FX_ORN, CBT_FX_LDC, CBT_FX_STC
	} cbt_fx_e;

	// -----------------------------------------------------------------
	// structs
	// -----------------------------------------------------------------
	typedef struct packed {
		logic       known;
		logic [1:0] len;
		logic [2:0] cyc_nt;
		logic [2:0] cyc_tk;
		cbt_cond_e  cond;
		cbt_fx_e    fx;
	} cbt_dec_s;

	typedef struct packed {
		logic       carry;
		logic       bitv;
		logic [7:0] acc;
		logic [7:0] lhs;
		logic [7:0] rhs;
		logic [7:0] dec;
	} cbt_opnd_s;

	typedef struct packed {
		logic       known;
		logic [1:0] len;
		logic [2:0] cycles;
		logic       taken;
		logic       carry_wr;
		logic       carry_val;
		logic       bit_wr;
		logic       bit_val;
		logic       dec_wr;
		logic [7:0] dec_val;
	} cbt_res_s;

endpackage : cbt_pkg

//--- rtl/cbt_timing.sv
// instruction length and cycle sequencer for carry-bit and branch operations
// assumes opcode and operands come from core logic on the same clock
`timescale 1ns/1ps
`include "cbt_map.svh"

module cbt_timing (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              start,
	input  wire logic [7:0]        opcode,
	input  wire cbt_pkg::cbt_opnd_s opnd,
	output logic                   ready,
	output logic                   busy,
	output logic                   done,
	output cbt_pkg::cbt_res_s      res
);

	// -----------------------------------------------------------------
	// decode
	// -----------------------------------------------------------------
	function automatic cbt_pkg::cbt_dec_s cbt_decode(input logic [7:0] op);
		cbt_pkg::cbt_dec_s d;
		d.known  = 1'b1;
		d.len    = `CBT_LEN_1;
		d.cyc_nt = `CBT_CYC_1;
		d.cyc_tk = `CBT_CYC_1;
		d.cond   = cbt_pkg::CBT_CND_NONE;
		d.fx     = cbt_pkg::CBT_FX_NONE;
		casez (op)
			`CBT_OP_ANDN: begin
				d.len = `CBT_LEN_2; d.cyc_nt = `CBT_CYC_2; d.fx = cbt_pkg::CBT_FX_ANDN;
			end
			`CBT_OP_OR: begin
				d.len = `CBT_LEN_2; d.cyc_nt = `CBT_CYC_2; d.fx = cbt_pkg::CBT_FX_OR;
			end
			`CBT_OP_ORN: begin
				d.len = `CBT_LEN_2; d.cyc_nt = `CBT_CYC_2; d.fx = cbt_pkg::CBT_FX_ORN;
			end
			`CBT_OP_LDC: begin
				d.len = `CBT_LEN_2; d.cyc_nt = `CBT_CYC_2; d.fx = cbt_pkg::CBT_FX_LDC;
			end
			`CBT_OP_STC: begin
				d.len = `CBT_LEN_2; d.cyc_nt = `CBT_CYC_2; d.fx = cbt_pkg::CBT_FX_STC;
			end
			`CBT_OP_JC, `CBT_OP_JNC: begin
				d.len = `CBT_LEN_2; d.cyc_nt = `CBT_CYC_2; d.cyc_tk = `CBT_CYC_3;
				d.cond = (op == `CBT_OP_JC) ? cbt_pkg::CBT_CND_C : cbt_pkg::CBT_CND_NC;
			end
			`CBT_OP_JB, `CBT_OP_JNB: begin
				d.len = `CBT_LEN_3; d.cyc_nt = `CBT_CYC_3; d.cyc_tk = `CBT_CYC_4;
				d.cond = (op == `CBT_OP_JB) ? cbt_pkg::CBT_CND_B : cbt_pkg::CBT_CND_NB;
			end
			`CBT_OP_JBC: begin
				d.len = `CBT_LEN_3; d.cyc_nt = `CBT_CYC_3; d.cyc_tk = `CBT_CYC_4;
				d.cond = cbt_pkg::CBT_CND_BC;
			end
			`CBT_OP_ABSOLUTE_CALL: begin
				d.len = `CBT_LEN_2; d.cyc_nt = `CBT_CYC_3;
			end
			`CBT_OP_LONG_CALL: begin
				d.len = `CBT_LEN_3; d.cyc_nt = `CBT_CYC_4;
			end
			`CBT_OP_RET, `CBT_OP_INTERRUPT_RETURN: begin
				d.len = `CBT_LEN_1; d.cyc_nt = `CBT_CYC_5;
			end
			`CBT_OP_SHORT_RELATIVE_JUMP: begin
				d.len = `CBT_LEN_2; d.cyc_nt = `CBT_CYC_3;
			end
			`CBT_OP_JMPI: begin
				d.len = `CBT_LEN_1; d.cyc_nt = `CBT_CYC_3;
			end
			`CBT_OP_JZ, `CBT_OP_JNZ: begin
				d.len = `CBT_LEN_2; d.cyc_nt = `CBT_CYC_2; d.cyc_tk = `CBT_CYC_3;
				d.cond = (op == `CBT_OP_JZ) ? cbt_pkg::CBT_CND_Z : cbt_pkg::CBT_CND_NZ;
			end
			`CBT_OP_CJD, `CBT_OP_CJI, `CBT_OP_CJR: begin
				d.len = `CBT_LEN_3; d.cyc_nt = `CBT_CYC_3; d.cyc_tk = `CBT_CYC_4;
				d.cond = cbt_pkg::CBT_CND_NE;
			end
			`CBT_OP_CJX: begin
				d.len = `CBT_LEN_3; d.cyc_nt = `CBT_CYC_4; d.cyc_tk = `CBT_CYC_5;
				d.cond = cbt_pkg::CBT_CND_NE;
			end
			`CBT_OP_DJR: begin
				d.len = `CBT_LEN_2; d.cyc_nt = `CBT_CYC_2; d.cyc_tk = `CBT_CYC_3;
				d.cond = cbt_pkg::CBT_CND_DJ;
			end
			`CBT_OP_DJD: begin
				d.len = `CBT_LEN_3; d.cyc_nt = `CBT_CYC_3; d.cyc_tk = `CBT_CYC_4;
				d.cond = cbt_pkg::CBT_CND_DJ;
			end
			default: begin
				// outside this block's set: one byte, one cycle, flagged unknown
				d.known = 1'b0;
			end
		endcase
		if (d.cond == cbt_pkg::CBT_CND_NONE) begin
			d.cyc_tk = d.cyc_nt;
		end
		return d;
	endfunction : cbt_decode

	// -----------------------------------------------------------------
	// branch condition
	// -----------------------------------------------------------------
	function automatic logic cbt_taken(input cbt_pkg::cbt_cond_e c,
	                                   input cbt_pkg::cbt_opnd_s o);
		logic t;
		t = 1'b0;
		case (c)
			cbt_pkg::CBT_CND_C:  t = o.carry;
			cbt_pkg::CBT_CND_NC: t = ~o.carry;
			cbt_pkg::CBT_CND_B:  t = o.bitv;
			cbt_pkg::CBT_CND_NB: t = ~o.bitv;
			cbt_pkg::CBT_CND_BC: t = o.bitv;
			cbt_pkg::CBT_CND_Z:  t = (o.acc == `CBT_BYTE_ZERO);
			cbt_pkg::CBT_CND_NZ: t = (o.acc != `CBT_BYTE_ZERO);
			cbt_pkg::CBT_CND_NE: t = (o.lhs != o.rhs);
			cbt_pkg::CBT_CND_DJ: t = (o.dec != `CBT_BYTE_ONE);
			default:             t = 1'b0;
		endcase
		return t;
	endfunction : cbt_taken

	// -----------------------------------------------------------------
	// sequencer
	// -----------------------------------------------------------------
	cbt_pkg::cbt_state_e state_q;
	cbt_pkg::cbt_state_e state_d;
	logic [2:0]          cnt_q;
	logic [2:0]          cnt_d;
	cbt_pkg::cbt_res_s   res_q;
	cbt_pkg::cbt_res_s   res_d;
	cbt_pkg::cbt_dec_s   dec_w;
	logic                take_w;
	logic                accept;

	assign dec_w  = cbt_decode(opcode);
	assign take_w = cbt_taken(dec_w.cond, opnd);
	assign busy   = (state_q == cbt_pkg::CBT_EXEC);
	assign done   = busy && (cnt_q == res_q.cycles);
	// back to back: a new opcode may enter in the final cycle of the last
	assign ready  = !busy || done;
	assign accept = start && ready;
	assign res    = res_q;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		res_d   = res_q;
		if (busy && !done) begin
			cnt_d = cnt_q + `CBT_CNT_FIRST;
		end
		if (accept) begin
			state_d          = cbt_pkg::CBT_EXEC;
			cnt_d            = `CBT_CNT_FIRST;
			res_d.known      = dec_w.known;
			res_d.len        = dec_w.len;
			res_d.taken      = take_w;
			res_d.cycles     = take_w ? dec_w.cyc_tk : dec_w.cyc_nt;
			res_d.carry_wr   = (dec_w.fx != cbt_pkg::CBT_FX_NONE) &&
			                   (dec_w.fx != cbt_pkg::CBT_FX_STC);
			res_d.carry_val  = opnd.carry;
			res_d.bit_wr     = (dec_w.fx == cbt_pkg::CBT_FX_STC) ||
			                   (dec_w.cond == cbt_pkg::CBT_CND_BC && take_w);
			res_d.bit_val    = (dec_w.fx == cbt_pkg::CBT_FX_STC) ? opnd.carry : 1'b0;
			res_d.dec_wr     = (dec_w.cond == cbt_pkg::CBT_CND_DJ);
			res_d.dec_val    = opnd.dec - `CBT_BYTE_ONE;
			case (dec_w.fx)
				cbt_pkg::CBT_FX_ANDN: res_d.carry_val = opnd.carry & ~opnd.bitv;
				cbt_pkg::CBT_FX_OR:   res_d.carry_val = opnd.carry | opnd.bitv;
				cbt_pkg::CBT_FX_ORN:  res_d.carry_val = opnd.carry | ~opnd.bitv;
				cbt_pkg::CBT_FX_LDC:  res_d.carry_val = opnd.bitv;
				default:              res_d.carry_val = opnd.carry;
			endcase
		end else if (done) begin
			state_d = cbt_pkg::CBT_IDLE;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= cbt_pkg::CBT_IDLE;
			cnt_q   <= `CBT_CNT_FIRST;
			res_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			res_q   <= res_d;
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	chk_andn_two_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_ANDN |=> !done ##1 (done && res.len == `CBT_LEN_2))
		else $error("and-not carry op timing wrong");
	chk_or_two_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_OR |=> !done ##1 (done && res.len == `CBT_LEN_2))
		else $error("or carry op timing wrong");
	chk_orn_two_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_ORN |=> !done ##1 (done && res.carry_wr))
		else $error("or-not carry op timing wrong");
	chk_ldc_carry_val: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_LDC |=> res.carry_val == $past(opnd.bitv) ##1 done)
		else $error("copy bit to carry wrong");
	chk_stc_bit_write: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_STC |=> (res.bit_wr && !done) ##1 done)
		else $error("copy carry to bit wrong");
	chk_carry_br_taken: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_JC && opnd.carry |=> (!done)[*2] ##1 done)
		else $error("carry branch taken timing wrong");
	chk_carry_br_skip: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_JNC && opnd.carry |=> !done ##1 done)
		else $error("carry branch skip timing wrong");
	chk_bit_br_taken: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_JNB && !opnd.bitv |=> (!done)[*3] ##1 done)
		else $error("bit branch timing wrong");
	chk_jbc_clears_bit: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_JBC && opnd.bitv |=> res.bit_wr && !res.bit_val
		&& res.cycles == `CBT_CYC_4)
		else $error("branch-and-clear wrong");
	chk_absolute_call_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode ==? `CBT_OP_ABSOLUTE_CALL |=> (!done)[*2] ##1 done)
		else $error("absolute call timing wrong");
	chk_long_call_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_LONG_CALL |=> (!done)[*3] ##1 (done && res.len == `CBT_LEN_3))
		else $error("long call timing wrong");
	chk_ret_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_RET |=> (!done)[*4] ##1 done)
		else $error("return timing wrong");
	chk_interrupt_return_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_INTERRUPT_RETURN |=> (busy && res.len == `CBT_LEN_1)[*5])
		else $error("interrupt return timing wrong");
	chk_short_relative_jump_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_SHORT_RELATIVE_JUMP |=> (!done)[*2] ##1 done)
		else $error("short jump timing wrong");
	chk_jmpi_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_JMPI |=> (!done)[*2] ##1 done)
		else $error("indirect jump timing wrong");
	chk_acc_br_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_JZ |=>
		res.cycles == ((|$past(opnd.acc)) ? `CBT_CYC_2 : `CBT_CYC_3))
		else $error("accumulator branch timing wrong");
	chk_compare_branch_not_equal_dir_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_CJD && opnd.lhs == opnd.rhs |=> (!done)[*2] ##1 done)
		else $error("compare direct timing wrong");
	chk_compare_branch_not_equal_imm_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_CJI && opnd.lhs != opnd.rhs |=> (!done)[*3] ##1 done)
		else $error("compare immediate timing wrong");
	chk_compare_branch_not_equal_reg_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode ==? `CBT_OP_CJR && opnd.lhs != opnd.rhs |=> (!done)[*3] ##1 done)
		else $error("compare register timing wrong");
	chk_compare_branch_not_equal_ind_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode ==? `CBT_OP_CJX && opnd.lhs != opnd.rhs |=> (!done)[*4] ##1 done)
		else $error("compare indirect timing wrong");
	chk_decrement_branch_nonzero_reg_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode ==? `CBT_OP_DJR && opnd.dec == `CBT_BYTE_ONE |=> !done ##1 done)
		else $error("decrement register timing wrong");
	chk_decrement_branch_nonzero_dir_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_DJD && opnd.dec != `CBT_BYTE_ONE |=> (!done)[*3] ##1 done)
		else $error("decrement direct timing wrong");
	chk_taken_long: assert property (@(posedge clk) disable iff (rst)
		accept && dec_w.cond != cbt_pkg::CBT_CND_NONE |=>
		res.cycles == ($past(take_w) ? $past(dec_w.cyc_tk) : $past(dec_w.cyc_nt)))
		else $error("taken branch count choice wrong");
	chk_done_at_count: assert property (@(posedge clk) disable iff (rst)
		done && !start |=> !busy)
		else $error("sequencer overran final cycle");
	chk_jc_skip_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_JC && !opnd.carry |=> !done ##1 done)
		else $error("carry branch skip timing wrong");
	chk_jnc_take_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_JNC && !opnd.carry |=> (!done)[*2] ##1 done)
		else $error("carry clear branch timing wrong");
	chk_jb_skip_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_JB && !opnd.bitv |=> (!done)[*2] ##1 done)
		else $error("bit branch skip timing wrong");
	chk_jb_take_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_JB && opnd.bitv |=> (!done)[*3] ##1 done)
		else $error("bit branch taken timing wrong");
	chk_jbc_skip_keep: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_JBC && !opnd.bitv |=> !res.bit_wr && res.cycles == `CBT_CYC_3)
		else $error("branch-and-clear skip wrong");
	chk_jz_take_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_JZ && opnd.acc == `CBT_BYTE_ZERO |=> (!done)[*2] ##1 done)
		else $error("zero branch taken timing wrong");
	chk_jnz_skip_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_JNZ && opnd.acc == `CBT_BYTE_ZERO |=> !done ##1 done)
		else $error("nonzero branch skip timing wrong");
	chk_cjd_take_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_CJD && opnd.lhs != opnd.rhs |=> (!done)[*3] ##1 done)
		else $error("compare direct taken timing wrong");
	chk_cji_skip_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_CJI && opnd.lhs == opnd.rhs |=> (!done)[*2] ##1 done)
		else $error("compare immediate skip timing wrong");
	chk_cjr_skip_len: assert property (@(posedge clk) disable iff (rst)
		accept && opcode ==? `CBT_OP_CJR && opnd.lhs == opnd.rhs |=>
		(!done)[*2] ##1 (done && res.len == `CBT_LEN_3))
		else $error("compare register skip wrong");
	chk_cjx_skip_len: assert property (@(posedge clk) disable iff (rst)
		accept && opcode ==? `CBT_OP_CJX && opnd.lhs == opnd.rhs |=>
		(!done)[*3] ##1 (done && res.len == `CBT_LEN_3))
		else $error("compare indirect skip wrong");
	chk_djr_take_val: assert property (@(posedge clk) disable iff (rst)
		accept && opcode ==? `CBT_OP_DJR && opnd.dec != `CBT_BYTE_ONE |=> (!done)[*2] ##1
		(done && res.dec_val == $past(opnd.dec, 3) - `CBT_BYTE_ONE))
		else $error("decrement register taken wrong");
	chk_djd_skip_cyc: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_DJD && opnd.dec == `CBT_BYTE_ONE |=> (!done)[*2] ##1 done)
		else $error("decrement direct skip timing wrong");
	chk_jmpi_len: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_JMPI |=> res.len == `CBT_LEN_1 && !res.taken)
		else $error("indirect jump length wrong");
	chk_short_relative_jump_len: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_SHORT_RELATIVE_JUMP |=> res.len == `CBT_LEN_2)
		else $error("short jump length wrong");
	chk_absolute_call_len: assert property (@(posedge clk) disable iff (rst)
		accept && opcode ==? `CBT_OP_ABSOLUTE_CALL |=> res.len == `CBT_LEN_2)
		else $error("absolute call length wrong");
	chk_stc_bit_val: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_STC |=> res.bit_val == $past(opnd.carry) && !res.carry_wr)
		else $error("copy carry to bit value wrong");
	chk_andn_val: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_ANDN |=> res.carry_val == ($past(opnd.carry) & ~$past(opnd.bitv)))
		else $error("and-not carry value wrong");
	chk_or_val: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_OR |=> res.carry_val == ($past(opnd.carry) | $past(opnd.bitv)))
		else $error("or carry value wrong");
	chk_orn_val: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_ORN |=> res.carry_val == ($past(opnd.carry) | ~$past(opnd.bitv)))
		else $error("or-not carry value wrong");
	chk_ldc_len: assert property (@(posedge clk) disable iff (rst)
		accept && opcode == `CBT_OP_LDC |=> res.len == `CBT_LEN_2 && res.carry_wr)
		else $error("copy bit to carry length wrong");
	chk_busy_no_take: assert property (@(posedge clk) disable iff (rst)
		start && !ready |=> $stable(res))
		else $error("request taken while busy");
	chk_done_one_cyc: assert property (@(posedge clk) disable iff (rst)
		done && !start |=> !done)
		else $error("done held past one cycle");

endmodule : cbt_timing

//--- testbench/tb_cbt_timing.sv
// self-checking bench for the carry-bit and branch timing sequencer
// assumes cbt_pkg is compiled first and cbt_map.svh is on the include path
`timescale 1ns/1ps
`include "cbt_map.svh"

module tb_cbt_timing;
	logic               clk;
	logic               rst;
	logic               start;
	logic [7:0]         opcode;
	cbt_pkg::cbt_opnd_s opnd;
	logic               ready;
	logic               busy;
	logic               done;
	cbt_pkg::cbt_res_s  res;
	int                 err_total;
	int                 comparisons;
	int                 cyc_cnt;
	logic [31:0]        seed;
	cbt_pkg::cbt_res_s  notes[$];
	logic               cnds[$];

	cbt_timing dut (.clk(clk), .rst(rst), .start(start), .opcode(opcode), .opnd(opnd),
		.ready(ready), .busy(busy), .done(done), .res(res));

	always #10 clk = ~clk;

	// -----------------------------------------------------------------
	// helpers
	// -----------------------------------------------------------------
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xorshift

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run

	// expected result of one opcode; cnd marks a two-count branch
	function automatic void expect_of(input logic [7:0] op, input cbt_pkg::cbt_opnd_s o,
		output cbt_pkg::cbt_res_s e, output logic cnd);
		logic [1:0] ln;
		logic [2:0] nt;
		logic [2:0] tk;
		logic       tkn;
		e = '0;
		e.known = 1'b1;
		tkn = 1'b0;
		ln = 2'h1;
		nt = 3'h1;
		tk = 3'h1;
		casez (op)
			8'hB0: begin ln = 2'h2; nt = 3'h2; tk = 3'h2; e.carry_wr = 1'b1; e.carry_val = o.carry & ~o.bitv; end
			8'h72: begin ln = 2'h2; nt = 3'h2; tk = 3'h2; e.carry_wr = 1'b1; e.carry_val = o.carry | o.bitv; end
			8'hA0: begin ln = 2'h2; nt = 3'h2; tk = 3'h2; e.carry_wr = 1'b1; e.carry_val = o.carry | ~o.bitv; end
			8'hA2: begin ln = 2'h2; nt = 3'h2; tk = 3'h2; e.carry_wr = 1'b1; e.carry_val = o.bitv; end
			8'h92: begin ln = 2'h2; nt = 3'h2; tk = 3'h2; e.bit_wr = 1'b1; e.bit_val = o.carry; end
			8'h40: begin ln = 2'h2; nt = 3'h2; tk = 3'h3; tkn = o.carry; end
			8'h50: begin ln = 2'h2; nt = 3'h2; tk = 3'h3; tkn = ~o.carry; end
			8'h20: begin ln = 2'h3; nt = 3'h3; tk = 3'h4; tkn = o.bitv; end
			8'h30: begin ln = 2'h3; nt = 3'h3; tk = 3'h4; tkn = ~o.bitv; end
			8'h10: begin ln = 2'h3; nt = 3'h3; tk = 3'h4; tkn = o.bitv; e.bit_wr = o.bitv; end
			8'b???1_0001: begin ln = 2'h2; nt = 3'h3; tk = 3'h3; end
			8'h12: begin ln = 2'h3; nt = 3'h4; tk = 3'h4; end
			8'h22: begin ln = 2'h1; nt = 3'h5; tk = 3'h5; end
			8'h32: begin ln = 2'h1; nt = 3'h5; tk = 3'h5; end
			8'h80: begin ln = 2'h2; nt = 3'h3; tk = 3'h3; end
			8'h73: begin ln = 2'h1; nt = 3'h3; tk = 3'h3; end
			8'h60: begin ln = 2'h2; nt = 3'h2; tk = 3'h3; tkn = (o.acc == 8'h00); end
			8'h70: begin ln = 2'h2; nt = 3'h2; tk = 3'h3; tkn = (o.acc != 8'h00); end
			8'hB5: begin ln = 2'h3; nt = 3'h3; tk = 3'h4; tkn = (o.lhs != o.rhs); end
			8'hB4: begin ln = 2'h3; nt = 3'h3; tk = 3'h4; tkn = (o.lhs != o.rhs); end
			8'b1011_1???: begin ln = 2'h3; nt = 3'h3; tk = 3'h4; tkn = (o.lhs != o.rhs); end
			8'b1011_011?: begin ln = 2'h3; nt = 3'h4; tk = 3'h5; tkn = (o.lhs != o.rhs); end
			8'b1101_1???: begin ln = 2'h2; nt = 3'h2; tk = 3'h3; tkn = (o.dec != 8'h01);
				e.dec_wr = 1'b1; e.dec_val = o.dec - 8'h01; end
			8'hD5: begin ln = 2'h3; nt = 3'h3; tk = 3'h4; tkn = (o.dec != 8'h01);
				e.dec_wr = 1'b1; e.dec_val = o.dec - 8'h01; end
			default: e.known = 1'b0;
		endcase
		e.len = ln;
		e.taken = tkn;
		e.cycles = tkn ? tk : nt;
		cnd = (nt != tk);
	endfunction : expect_of

	// entered at a rising edge; returns at the accepting edge with start still high
	task automatic issue(input logic [7:0] op);
		cbt_pkg::cbt_opnd_s o;
		cbt_pkg::cbt_res_s  e;
		logic               c;
		int                 n;
		seed = xorshift(seed);
		o.carry = seed[0];
		o.bitv = seed[1];
		// bias operands so both branch outcomes occur often
		o.acc = seed[2] ? 8'h00 : seed[15:8];
		o.lhs = seed[23:16];
		o.rhs = seed[3] ? seed[23:16] : seed[31:24];
		o.dec = seed[4] ? 8'h01 : seed[12:5];
		expect_of(op, o, e, c);
		notes.push_back(e);
		cnds.push_back(c);
		start <= 1'b1;
		opcode <= op;
		opnd <= o;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (ready !== 1'b1 && n < 8);
		if (n >= 8)
			check(32'h0, 32'h1, "ready never rose");
		@(posedge clk);
	endtask : issue

	// -----------------------------------------------------------------
	// monitor: one note per done pulse, counted in busy cycles
	// -----------------------------------------------------------------
	always @(negedge clk) begin
		cbt_pkg::cbt_res_s e;
		logic              c;
		if (rst) begin
			cyc_cnt = 0;
			notes.delete();
			cnds.delete();
		end else begin
			if (busy === 1'b1)
				cyc_cnt++;
			if (done === 1'b1) begin
				if (notes.size() == 0) begin
					check(32'h1, 32'h0, "done with nothing pending");
				end else begin
					e = notes.pop_front();
					c = cnds.pop_front();
					check(cyc_cnt, e.cycles, "busy cycles");
					check(res.cycles, e.cycles, "reported cycles");
					check(res.len, e.len, "length");
					check(res.known, e.known, "decode");
					if (c)
						check(res.taken, e.taken, "taken");
					check({res.carry_wr, res.bit_wr, res.dec_wr},
						{e.carry_wr, e.bit_wr, e.dec_wr}, "effect enables");
					if (e.carry_wr)
						check(res.carry_val, e.carry_val, "carry value");
					if (e.bit_wr)
						check(res.bit_val, e.bit_val, "bit value");
					if (e.dec_wr)
						check(res.dec_val, e.dec_val, "decremented value");
					check(ready, 1'b1, "ready in final cycle");
				end
				cyc_cnt = 0;
			end
		end
	end

	// -----------------------------------------------------------------
	// main sequence
	// -----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		start = 1'b0;
		opcode = 8'h00;
		opnd = '0;
		err_total = 0;
		comparisons = 0;
		cyc_cnt = 0;
		seed = 32'h0001845F;
		repeat (4) @(posedge clk);
		check({busy, done, ready, res}, {2'b00, 1'b1, 20'h00000}, "reset values");
		rst <= 1'b0;
		// every opcode back to back, then again with idle gaps
		for (int i = 0; i < 256; i++)
			issue(i[7:0]);
		for (int i = 0; i < 256; i++) begin
			issue(i[7:0]);
			start <= 1'b0;
			@(posedge clk);
		end
		// a request while busy is ignored
		issue(8'h12);
		opcode <= 8'h40;
		@(posedge clk);
		start <= 1'b0;
		repeat (6) @(posedge clk);
		// reset in mid-instruction drops it at once
		issue(8'h22);
		start <= 1'b0;
		@(posedge clk);
		rst <= 1'b1;
		@(negedge clk);
		check({busy, done, ready, res}, {2'b00, 1'b1, 20'h00000}, "mid-run reset");
		@(posedge clk);
		rst <= 1'b0;
		issue(8'h32);
		start <= 1'b0;
		repeat (8) @(posedge clk);
		check(notes.size(), 32'h0, "results still pending");
		complete_run();
	end

	// watchdog well beyond about 1000 cycles of traffic
	initial begin
		repeat (6000) @(posedge clk);
		err_total++;
		$display("ERROR %0t: watchdog expired", $time);
		complete_run();
	end

endmodule : tb_cbt_timing
